// >>> rtl/aic_map.svh
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH
`define AIC_SUB_VERSION 8'h00
`define AIC_SUB_DELAY 8'h01
`define AIC_SUB_INPUT 8'h02
`define AIC_BIT_WP_DIS 6
`define AIC_DELAY_RST 7'h07
`define AIC_APPLIED_RST 4'h7
`define AIC_INPUT_RST 8'h00
`define AIC_DELAY_HOLD 4'hf
`endif

// >>> rtl/aic_pkg.sv
package aic_pkg;
    // Broad class of input routing
    typedef enum logic [2:0] {
        AIC_CVBS, AIC_YC_PROG, AIC_YC_FOLLOW, AIC_COMPONENT, AIC_RGB, AIC_RESERVED
    } aic_route_t;
endpackage

// >>> rtl/aic_regs.sv
`timescale 1ns/1ps
`include "aic_map.svh"
module aic_regs (
    sys_clk,
    rst_b,
    wr_en,
    rd_en,
    sub_addr,
    wr_data,
    rd_data,
    white_peak_active,
    gain_step,
    adc_align_delay,
    delay_update,
    amp_enable,
    aaf_enable,
    input_mode,
    route_class,
    luma_agc,
    chroma_gain_prog
);
    import aic_pkg::*;

    // Arbitrary chip version value; any nibble will do
    parameter logic [3:0] CHIP_VERSION = 4'h1;

    // Clock and reset pins
    input wire logic sys_clk; // System clock, 250 MHz
    input wire logic rst_b; // Reset pin, active low, asynchronous

    // Control bus side, already in the sys_clk domain
    input wire logic wr_en; // One-cycle write strobe
    input wire logic rd_en; // One-cycle read strobe
    input wire logic [7:0] sub_addr; // Register subaddress
    input wire logic [7:0] wr_data; // Byte to be written

    // Read data, held until the next read
    output logic [7:0] rd_data;

    // Steering towards the luma processing path
    output logic white_peak_active; // Attenuate above nominal white
    output logic [1:0] gain_step; // Gain update step size code
    output logic [3:0] adc_align_delay; // Delay actually applied
    output logic delay_update; // High when the delay code loads

    // Steering towards the analog front end
    output logic amp_enable; // Input amplifier in use
    output logic aaf_enable; // Anti-alias filter in use
    output logic [5:0] input_mode; // Raw input routing code
    output aic_pkg::aic_route_t route_class; // Broad routing class
    output logic luma_agc; // Automatic gain on luma or sync
    output logic chroma_gain_prog; // Chroma gain from its own bits

    // Reset release synchroniser; only the second stage is used
    logic rst_s1_q;
    logic rst_s2_q;

    // Stored register contents
    logic [6:0] delay_q; // Subaddress 01, bit 7 not kept
    logic [7:0] input_q; // Subaddress 02, all eight bits

    // Delay in use; survives a hold code
    logic [3:0] applied_q;

    // Subaddress match, shared by the write and read decoders
    function automatic logic sub_hit(input logic [7:0] addr, input logic [7:0] code);
        sub_hit = (addr == code);
    endfunction

    // Classify a mode code into its routing family
    function automatic aic_route_t classify(input logic [5:0] m);
        // First composite group
        if (m <= 6'h05) begin
            classify = AIC_CVBS;
        // Luma-chroma pairs with chroma gain from its own bits
        end else if (m == 6'h06 || m == 6'h07 || m == 6'h0a || m == 6'h0b) begin
            classify = AIC_YC_PROG;
        // Remaining pairs below 0e follow the luma gain
        end else if (m <= 6'h0d) begin
            classify = AIC_YC_FOLLOW;
        // Second and third composite groups
        end else if (m <= 6'h15 || m == 6'h1e || m == 6'h1f) begin
            classify = AIC_CVBS;
        // Upper luma-chroma pairs; bit 1 picks own chroma gain
        end else if (m <= 6'h1d) begin
            classify = m[1] ? AIC_YC_PROG : AIC_YC_FOLLOW;
        // Component inputs with separate sync channel
        end else if (m == 6'h20 || m == 6'h21 || m == 6'h2e || m == 6'h2f) begin
            classify = AIC_COMPONENT;
        // Whole upper quarter taken as RGB
        end else if (m[5:4] == 2'b11) begin
            classify = AIC_RGB;
        // Gap between component codes stays unused
        end else begin
            classify = AIC_RESERVED;
        end
    endfunction

    // Release reset through two flops
    // Assertion stays asynchronous, release is clean to sys_clk
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Both stages clear at once
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            // Shift a one through
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Writes to subaddress 01
    // Bit 7 has no meaning here, so it is dropped, not stored
    always_ff @(posedge sys_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            // Recommended delay, white peak control on
            delay_q <= `AIC_DELAY_RST;
        end else if (wr_en && sub_hit(sub_addr, `AIC_SUB_DELAY)) begin
            // Store the low seven bits
            delay_q <= wr_data[6:0];
        end
    end

    // Writes to subaddress 02
    always_ff @(posedge sys_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            // Bypassed front end, first composite input
            input_q <= `AIC_INPUT_RST;
        end else if (wr_en && sub_hit(sub_addr, `AIC_SUB_INPUT)) begin
            // Whole byte is meaningful
            input_q <= wr_data;
        end
    end

    // Applied delay follows the stored code one cycle later
    // Code 1111 keeps the previous delay rather than loading it,
    // so software can touch the other bits without a delay glitch
    always_ff @(posedge sys_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            // Same as the stored reset code
            applied_q <= `AIC_APPLIED_RST;
        end else if (delay_q[3:0] != `AIC_DELAY_HOLD) begin
            // Load any code but the hold code
            applied_q <= delay_q[3:0];
        end
    end

    // Read mux, registered
    // Data stands until the next read strobe
    always_ff @(posedge sys_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            // Quiet bus after reset
            rd_data <= 8'h00;
        end else if (rd_en) begin
            // Version in the upper nibble, lower nibble zero
            if (sub_hit(sub_addr, `AIC_SUB_VERSION)) begin
                rd_data <= {CHIP_VERSION, 4'h0};
            // Unused bit 7 reads as zero
            end else if (sub_hit(sub_addr, `AIC_SUB_DELAY)) begin
                rd_data <= {1'b0, delay_q};
            // Full byte back
            end else if (sub_hit(sub_addr, `AIC_SUB_INPUT)) begin
                rd_data <= input_q;
            // Subaddresses outside this bank
            end else begin
                rd_data <= 8'h00;
            end
        end
    end

    // Steering outputs derived from stored fields
    // Combinational on purpose: all but adc_align_delay change the cycle after a write
    always_comb begin
        // Luma path controls
        white_peak_active = !delay_q[`AIC_BIT_WP_DIS];
        gain_step = delay_q[5:4];
        adc_align_delay = applied_q;
        delay_update = (delay_q[3:0] != `AIC_DELAY_HOLD);
        // Function select: 00 and 01 both bypass
        amp_enable = input_q[7];
        aaf_enable = input_q[7] & input_q[6];
        // Routing
        input_mode = input_q[5:0];
        route_class = classify(input_q[5:0]);
        // Every defined mode runs some automatic gain
        luma_agc = (route_class != AIC_RESERVED);
        chroma_gain_prog = (route_class == AIC_YC_PROG);
    end
endmodule

// >>> bench/aic_regs_properties.sv
`timescale 1ns/1ps
module aic_regs_properties #(parameter logic [3:0] CHIP_VERSION = 4'h1) (
    input wire logic sys_clk, rst_b, wr_en, rd_en, white_peak_active, delay_update,
    input wire logic amp_enable, aaf_enable, luma_agc, chroma_gain_prog,
    input wire logic [7:0] sub_addr, wr_data, rd_data,
    input wire logic [1:0] gain_step,
    input wire logic [3:0] adc_align_delay,
    input wire logic [5:0] input_mode,
    input wire aic_pkg::aic_route_t route_class
);
    import aic_pkg::*;
    wire logic w1 = wr_en && sub_addr == 8'h01; // Delay register write
    wire logic w2 = wr_en && sub_addr == 8'h02; // Input register write
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_ver; rd_en && sub_addr == 8'h00 |=> rd_data == {CHIP_VERSION, 4'h0}; endproperty
    a_ver: assert property (p_ver) else $error("ver");
    property p_wp; w1 |=> white_peak_active != $past(wr_data[6]); endproperty
    a_wp: assert property (p_wp) else $error("wp");
    property p_gs; w1 |=> gain_step == $past(wr_data[5:4]); endproperty
    a_gs: assert property (p_gs) else $error("gs");
    // Applied delay lags the register by one more cycle
    property p_dl; w1 && wr_data[3:0] != 4'hf |=> ##1
        adc_align_delay == $past(wr_data[3:0], 2); endproperty
    a_dl: assert property (p_dl) else $error("dl");
    property p_hd; !delay_update |=> $stable(adc_align_delay); endproperty
    a_hd: assert property (p_hd) else $error("hd");
    property p_fn; w2 |=> amp_enable == $past(wr_data[7]) &&
        aaf_enable == &$past(wr_data[7:6]); endproperty
    a_fn: assert property (p_fn) else $error("fn");
    property p_cv; input_mode < 6'h06 |-> route_class == AIC_CVBS && luma_agc; endproperty
    a_cv: assert property (p_cv) else $error("cv");
    property p_yc; input_mode inside {[6'h06:6'h0d]} |-> chroma_gain_prog == input_mode[1];
    endproperty
    a_yc: assert property (p_yc) else $error("yc");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
bind aic_regs aic_regs_properties #(.CHIP_VERSION(CHIP_VERSION)) i_props (.*);
module testbench;
    import aic_pkg::*;
    logic sys_clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, white_peak_active, delay_update;
    logic amp_enable, aaf_enable, luma_agc, chroma_gain_prog;
    logic [7:0] sub_addr = 8'h00, wr_data = 8'h00, rd_data;
    logic [1:0] gain_step;
    logic [3:0] adc_align_delay;
    logic [5:0] input_mode;
    aic_route_t route_class;
    int num_errors, checks;
    logic [5:0] md [8] = '{6'h16, 6'h18, 6'h1e, 6'h20, 6'h22, 6'h2f, 6'h30, 6'h3f};
    aic_route_t rc [8] = '{AIC_YC_PROG, AIC_YC_FOLLOW, AIC_CVBS, AIC_COMPONENT,
        AIC_RESERVED, AIC_COMPONENT, AIC_RGB, AIC_RGB};
    always #2 sys_clk = ~sys_clk;
    aic_regs #(.CHIP_VERSION(4'h5)) i_dut (.*);
    task automatic chk(string n, logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // Write when w, else read and expect d
    task automatic acc(logic w, logic [7:0] a, d);
        @(posedge sys_clk) {wr_en, rd_en, sub_addr, wr_data} <= {w, !w, a, d};
        @(posedge sys_clk) {wr_en, rd_en} <= 2'b00;
        @(negedge sys_clk) if (!w) chk("rd", rd_data, d);
    endtask
    task automatic close_out();
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        acc(1'b0, 8'h00, 8'h50);
        acc(1'b1, 8'h00, 8'hff);
        acc(1'b0, 8'h00, 8'h50);
        acc(1'b0, 8'h05, 8'h00);
        acc(1'b0, 8'h01, 8'h07);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h01, {1'b0, i[0], i[1:0], 4'he});
            chk("wp", white_peak_active, !i[0]);
            chk("gs", gain_step, i[1:0]);
            chk("upd", delay_update, 1'b1);
            @(negedge sys_clk) chk("dly", adc_align_delay, 8'h0e);
        end
        acc(1'b1, 8'h01, 8'h8f);
        chk("upd", delay_update, 1'b0);
        @(negedge sys_clk) chk("hold", adc_align_delay, 8'h0e);
        acc(1'b0, 8'h01, 8'h0f);
        acc(1'b1, 8'h01, 8'h07);
        @(negedge sys_clk) chk("dly", adc_align_delay, 8'h07);
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, 8'h02, {i[1:0], i[5:0]});
            chk("fn", {amp_enable, aaf_enable}, {i[1], &i[1:0]});
            chk("cvbs", route_class == AIC_CVBS, i < 6 || i > 13);
            chk("cgp", chroma_gain_prog, i > 5 && i < 14 && i[1]);
            chk("mode", input_mode, i[5:0]);
            chk("agc", luma_agc, 1'b1);
            acc(1'b0, 8'h02, {i[1:0], i[5:0]});
        end
        for (int k = 0; k < 8; k++) begin
            acc(1'b1, 8'h02, {2'b11, md[k]});
            chk("cls", route_class, rc[k]);
            chk("agc", luma_agc, rc[k] != AIC_RESERVED);
        end
        close_out();
    end
endmodule
